// ### design/adcc_top.sv
// converter control, command sequencing and warm-up with an APB slave
`timescale 1ns/1ps
`include "adcc_regs.svh"

// Behaviour
// - ratio codes 9, 10 and 11 accumulate 1024, 2048 and 4096 samples.
// - converter warm-up lasts time unit plus one peripheral clock cycles.
// - reference warm-up lasts five times (time unit plus one) cycles.
// - the converter clock toggles every setting+1 peripheral clock cycles.
// - filter 0 selects nothing, 1 decoupling, 2 the RC filter.
// - without tailgating a scan wins but waits for a running single.
// - with tailgating a single starts only right after a scan ends.
// - retention 0 powers the converter down after every conversion.
// - retention 1 skips the reference warm-up.
// - retention 2 keeps the scan reference warm between conversions.
// - retention 3 keeps converter and scan reference warm.
// - writing one to command bits 0..3 starts or stops single or scan.
module adcc_top #(
  parameter int AW = 12,
  parameter int DW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output adcc_pkg::adcc_core_t core,
  input wire logic core_done,
  input wire logic [DW-1:0] core_data
);
  import adcc_pkg::*;

  localparam int AccW = DW + 12;

  adcc_ctrl_t ctrl_r;
  logic [3:0] ovs_code_r;
  logic ovs_en_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  adcc_core_t core_r;
  adcc_state_t state_r, state_nxt;
  logic single_pend_r, scan_pend_r, job_scan_r, abort_r, scan_done_r;
  logic conv_warm_r, ref_warm_r;
  logic smp_busy_r;
  logic [12:0] smp_cnt_r;
  logic [AccW-1:0] acc_r;
  logic [DW-1:0] single_res_r, scan_res_r;
  logic single_dv_r, scan_dv_r;
  logic done_m_r, done_s_r, done_d_r;

  logic setup, wr, rd, mapped;
  logic [31:0] rd_val;
  logic cmd_wr, sgl_go, sgl_halt, seq_go, seq_halt;
  logic tick, wdone, need_ref, grant_scan, grant_single;
  logic done_rise, finish, stop_now, job_end;
  logic [3:0] code_eff;
  logic [12:0] n_smp;
  logic [AccW-1:0] sum;
  logic [7:0] unit_len, warm_len;
  logic [7:0] clock_divider_setting_len;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign core = core_r;

  // ---------------- APB slave: one wait-free access phase ----------------
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_r && pwrite;
  assign rd = psel && penable && pready_r && !pwrite;
  assign mapped = (paddr == `ADCC_OFF_CTRL) || (paddr == `ADCC_OFF_CMD)
               || (paddr == `ADCC_OFF_STATUS) || (paddr == `ADCC_OFF_OVS)
               || (paddr == `ADCC_OFF_SDATA) || (paddr == `ADCC_OFF_QDATA);

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `ADCC_OFF_CTRL: begin
        rd_val[`ADCC_TB_MSB:`ADCC_TB_LSB] = ctrl_r.warmup_time_unit;
        rd_val[`ADCC_CLOCK_DIVIDER_SETTING_MSB:`ADCC_CLOCK_DIVIDER_SETTING_LSB] =
          ctrl_r.clock_divider_setting;
        rd_val[`ADCC_FILT_MSB:`ADCC_FILT_LSB] = ctrl_r.input_filter_select;
        rd_val[`ADCC_TAIL_BIT] = ctrl_r.single_after_scan;
        rd_val[`ADCC_MODE_MSB:`ADCC_MODE_LSB] = ctrl_r.warm_retention_select;
      end
      `ADCC_OFF_STATUS: begin
        rd_val[0] = (state_r != ADCC_S_IDLE) && !job_scan_r;
        rd_val[1] = (state_r != ADCC_S_IDLE) && job_scan_r;
        rd_val[2] = single_pend_r;
        rd_val[3] = scan_pend_r;
        rd_val[4] = conv_warm_r;
        rd_val[5] = ref_warm_r;
        rd_val[8] = single_dv_r;
        rd_val[9] = scan_dv_r;
      end
      `ADCC_OFF_OVS: begin
        rd_val[3:0] = ovs_code_r;
        rd_val[`ADCC_OVS_EN_BIT] = ovs_en_r;
      end
      `ADCC_OFF_SDATA: rd_val[DW-1:0] = single_res_r;
      `ADCC_OFF_QDATA: rd_val[DW-1:0] = scan_res_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r <= setup ? rd_val : 32'h0000_0000;
    end
  end

  // reserved positions are dropped on write and read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r.warmup_time_unit <= `ADCC_TB_RST;
      ctrl_r.clock_divider_setting <= `ADCC_CLOCK_DIVIDER_SETTING_RST;
      ctrl_r.input_filter_select <= `ADCC_FILT_RST;
      ctrl_r.single_after_scan <= 1'b0;
      ctrl_r.warm_retention_select <= `ADCC_MODE_RST;
      ovs_code_r <= 4'h0;
      ovs_en_r <= 1'b0;
    end else if (wr && paddr == `ADCC_OFF_CTRL) begin
      ctrl_r.warmup_time_unit <= pwdata[`ADCC_TB_MSB:`ADCC_TB_LSB];
      ctrl_r.clock_divider_setting <= pwdata[`ADCC_CLOCK_DIVIDER_SETTING_MSB:`ADCC_CLOCK_DIVIDER_SETTING_LSB];
      ctrl_r.input_filter_select <= pwdata[`ADCC_FILT_MSB:`ADCC_FILT_LSB];
      ctrl_r.single_after_scan <= pwdata[`ADCC_TAIL_BIT];
      ctrl_r.warm_retention_select <= pwdata[`ADCC_MODE_MSB:`ADCC_MODE_LSB];
    end else if (wr && paddr == `ADCC_OFF_OVS) begin
      ovs_code_r <= pwdata[3:0];
      ovs_en_r <= pwdata[`ADCC_OVS_EN_BIT];
    end
  end

  // ---------------- commands ----------------
  assign cmd_wr = wr && (paddr == `ADCC_OFF_CMD);
  assign sgl_go = cmd_wr && pwdata[`ADCC_CMD_SGL_GO];
  assign sgl_halt = cmd_wr && pwdata[`ADCC_CMD_SGL_HALT];
  assign seq_go = cmd_wr && pwdata[`ADCC_CMD_SEQ_GO];
  assign seq_halt = cmd_wr && pwdata[`ADCC_CMD_SEQ_HALT];

  // a start that meets its own grant stays pending; a stop beats a start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_pend_r <= 1'b0;
      scan_pend_r <= 1'b0;
    end else begin
      if (sgl_halt) single_pend_r <= 1'b0;
      else if (sgl_go) single_pend_r <= 1'b1;
      else if (grant_single) single_pend_r <= 1'b0;
      if (seq_halt) scan_pend_r <= 1'b0;
      else if (seq_go) scan_pend_r <= 1'b1;
      else if (grant_scan) scan_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_r <= 1'b0;
    end else if (state_nxt == ADCC_S_IDLE) begin
      abort_r <= 1'b0;
    end else if ((sgl_halt && !job_scan_r) || (seq_halt && job_scan_r)) begin
      abort_r <= state_r != ADCC_S_IDLE;
    end
  end

  // ---------------- converter clock and warm-up timing ----------------
  assign clock_divider_setting_len = {1'b0, ctrl_r.clock_divider_setting} + 8'h01;
  assign unit_len = {3'b000, ctrl_r.warmup_time_unit} + 8'h01;
  // longest bandgap count is 160 cycles, so eight bits suffice
  assign warm_len = (state_r == ADCC_S_REFW) ?
                    8'(unit_len * `ADCC_BG_MULT) : unit_len;

  adcc_timer #(.W(8)) u_clock_divider_setting (
    .pclk(pclk),
    .presetn(presetn),
    .run(1'b1),
    .len(clock_divider_setting_len),
    .done(tick)
  );

  adcc_timer #(.W(8)) u_warm (
    .pclk(pclk),
    .presetn(presetn),
    .run((state_r == ADCC_S_WARM) || (state_r == ADCC_S_REFW)),
    .len(warm_len),
    .done(wdone)
  );

  // ---------------- sequencer ----------------
  assign grant_scan = (state_r == ADCC_S_IDLE) && scan_pend_r;
  assign grant_single = (state_r == ADCC_S_IDLE) && single_pend_r
    && !scan_pend_r
    && (!ctrl_r.single_after_scan || scan_done_r);
  // the fast-reference mode never waits for the bandgap
  assign need_ref = (ctrl_r.warm_retention_select != `ADCC_MODE_FASTREF)
    && !(ref_warm_r && job_scan_r);
  assign stop_now = abort_r && tick;
  assign done_rise = done_s_r && !done_d_r;
  assign code_eff = (ovs_code_r > `ADCC_OVS_CODE_MAX) ?
                    `ADCC_OVS_CODE_MAX : ovs_code_r;
  // code c gives 2^(c+1) samples: 9 -> 1024, 10 -> 2048, 11 -> 4096
  assign n_smp = ovs_en_r ? (13'h0002 << code_eff) : 13'h0001;
  assign sum = acc_r + {{(AccW-DW){1'b0}}, core_data};
  assign finish = (state_r == ADCC_S_CONV) && done_rise && smp_busy_r
    && !stop_now && (smp_cnt_r == n_smp - 13'h0001);
  assign job_end = (state_r != ADCC_S_IDLE) && (state_nxt == ADCC_S_IDLE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ADCC_S_IDLE: begin
        if (grant_scan || grant_single) begin
          if (!conv_warm_r) state_nxt = ADCC_S_WARM;
          else state_nxt = ADCC_S_CONV;
        end
      end
      ADCC_S_WARM: begin
        if (stop_now) state_nxt = ADCC_S_IDLE;
        else if (wdone && need_ref) state_nxt = ADCC_S_REFW;
        else if (wdone) state_nxt = ADCC_S_CONV;
      end
      ADCC_S_REFW: begin
        if (stop_now) state_nxt = ADCC_S_IDLE;
        else if (wdone) state_nxt = ADCC_S_CONV;
      end
      ADCC_S_CONV: begin
        if (stop_now || finish) state_nxt = ADCC_S_IDLE;
      end
      default: state_nxt = ADCC_S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ADCC_S_IDLE;
      job_scan_r <= 1'b0;
      scan_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (grant_scan || grant_single) job_scan_r <= grant_scan;
      scan_done_r <= finish && job_scan_r;
    end
  end

  // retention decided at the end of every job, aborted or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_warm_r <= 1'b0;
      ref_warm_r <= 1'b0;
    end else if (job_end) begin
      conv_warm_r <= ctrl_r.warm_retention_select == `ADCC_MODE_KEEPALL;
      ref_warm_r <= job_scan_r
        && ctrl_r.warm_retention_select[1];
    end else if (state_r == ADCC_S_WARM && wdone) begin
      conv_warm_r <= 1'b1;
    end else if (state_r == ADCC_S_REFW && wdone) begin
      ref_warm_r <= 1'b1;
    end else if (state_r == ADCC_S_IDLE) begin
      if (ctrl_r.warm_retention_select != `ADCC_MODE_KEEPALL)
        conv_warm_r <= 1'b0;
      if (!ctrl_r.warm_retention_select[1]) ref_warm_r <= 1'b0;
    end
  end

  // ---------------- sampling and accumulation ----------------
  // done comes from the analog side, so it is synchronised first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_m_r <= 1'b0;
      done_s_r <= 1'b0;
      done_d_r <= 1'b0;
    end else begin
      done_m_r <= core_done;
      done_s_r <= done_m_r;
      done_d_r <= done_s_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_busy_r <= 1'b0;
      smp_cnt_r <= 13'h0000;
      acc_r <= '0;
    end else if (state_r != ADCC_S_CONV || stop_now || finish) begin
      smp_busy_r <= 1'b0;
      smp_cnt_r <= 13'h0000;
      acc_r <= '0;
    end else if (smp_busy_r && done_rise) begin
      smp_busy_r <= 1'b0;
      smp_cnt_r <= smp_cnt_r + 13'h0001;
      acc_r <= sum;
    end else if (!smp_busy_r && tick) begin
      smp_busy_r <= 1'b1;
    end
  end

  // a result read clears its flag unless a new result lands the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_res_r <= '0;
      scan_res_r <= '0;
      single_dv_r <= 1'b0;
      scan_dv_r <= 1'b0;
    end else begin
      if (finish && !job_scan_r) begin
        single_res_r <= DW'(sum >> (ovs_en_r ? code_eff + 4'h1 : 4'h0));
        single_dv_r <= 1'b1;
      end else if (rd && paddr == `ADCC_OFF_SDATA) begin
        single_dv_r <= 1'b0;
      end
      if (finish && job_scan_r) begin
        scan_res_r <= DW'(sum >> (ovs_en_r ? code_eff + 4'h1 : 4'h0));
        scan_dv_r <= 1'b1;
      end else if (rd && paddr == `ADCC_OFF_QDATA) begin
        scan_dv_r <= 1'b0;
      end
    end
  end

  // ---------------- pins toward the converter core ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_r <= '0;
    end else begin
      core_r.power_en <= (state_nxt != ADCC_S_IDLE) || conv_warm_r;
      core_r.ref_en <= (state_nxt == ADCC_S_REFW)
        || (state_nxt == ADCC_S_CONV) || ref_warm_r;
      core_r.onchip_decoupling <=
        ctrl_r.input_filter_select == `ADCC_FILT_ONCHIP_DECOUPLING;
      core_r.resistor_capacitor_filter <=
        ctrl_r.input_filter_select == `ADCC_FILT_RC;
      core_r.sample_req <= (state_r == ADCC_S_CONV) && !smp_busy_r
        && tick && !stop_now && !finish;
      core_r.sample_scan <= job_scan_r;
      if (tick) core_r.conv_clk <= !core_r.conv_clk;
    end
  end

  // ---------------- checks ----------------
  logic [7:0] st_cyc_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_cyc_r <= 8'h01;
    else if (state_nxt != state_r) st_cyc_r <= 8'h01;
    else st_cyc_r <= st_cyc_r + 8'h01;
  end

  a_ovs_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    (ovs_en_r && ovs_code_r == 4'hA) |-> n_smp == 13'd2048)
    else $error("ratio code 10 does not give 2048 samples");
  a_warm_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ADCC_S_WARM && wdone && !stop_now)
      |-> st_cyc_r == unit_len)
    else $error("converter warm-up length wrong");
  a_ref_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ADCC_S_REFW && wdone && !stop_now)
      |-> st_cyc_r == 8'(unit_len * 8'h05))
    else $error("bandgap warm-up length wrong");
  a_div_tick: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> core_r.conv_clk != $past(core_r.conv_clk))
    else $error("converter clock did not follow the divider");
  a_filter_pins: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 core_r.onchip_decoupling == ($past(ctrl_r.input_filter_select) == 2'h1)
    && core_r.resistor_capacitor_filter
       == ($past(ctrl_r.input_filter_select) == 2'h2))
    else $error("filter pins disagree with select");
  a_scan_first: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ADCC_S_IDLE && scan_pend_r) |=> job_scan_r)
    else $error("single won over a pending scan");
  a_tail_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ADCC_S_IDLE && state_nxt != ADCC_S_IDLE && !scan_pend_r
     && ctrl_r.single_after_scan) |-> $past(finish && job_scan_r))
    else $error("single started while not right after scan");
  a_mode0_down: assert property (@(posedge pclk) disable iff (!presetn)
    (job_end && ctrl_r.warm_retention_select == 2'h0)
      |=> !conv_warm_r ##1 !core_r.power_en || state_r != ADCC_S_IDLE)
    else $error("converter left powered in retention mode 0");
  a_fast_ref: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.warm_retention_select == 2'h1 && state_r == ADCC_S_WARM)
      |=> state_r != ADCC_S_REFW)
    else $error("reference warm-up run in fast mode");
  a_keep_ref: assert property (@(posedge pclk) disable iff (!presetn)
    (job_end && job_scan_r && ctrl_r.warm_retention_select == 2'h2)
      |=> ref_warm_r && !conv_warm_r)
    else $error("scan reference not retained");
  a_keep_all: assert property (@(posedge pclk) disable iff (!presetn)
    (job_end && ctrl_r.warm_retention_select == 2'h3) |=> conv_warm_r)
    else $error("converter not retained");
  a_cmd_start: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_go && !seq_halt) |=> scan_pend_r)
    else $error("scan start command lost");
  a_stop_abort: assert property (@(posedge pclk) disable iff (!presetn)
    stop_now |=> state_r == ADCC_S_IDLE && !scan_done_r && !smp_busy_r)
    else $error("stop did not abort cleanly");

endmodule : adcc_top

// ### design/adcc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_OFF_CTRL 12'h000
`define ADCC_OFF_CMD 12'h004
`define ADCC_OFF_STATUS 12'h008
`define ADCC_OFF_OVS 12'h00C
`define ADCC_OFF_SDATA 12'h010
`define ADCC_OFF_QDATA 12'h014

`define ADCC_TB_MSB 20
`define ADCC_TB_LSB 16
`define ADCC_CLOCK_DIVIDER_SETTING_MSB 14
`define ADCC_CLOCK_DIVIDER_SETTING_LSB 8
`define ADCC_FILT_MSB 5
`define ADCC_FILT_LSB 4
`define ADCC_TAIL_BIT 3
`define ADCC_MODE_MSB 1
`define ADCC_MODE_LSB 0

`define ADCC_TB_RST 5'h1F
`define ADCC_CLOCK_DIVIDER_SETTING_RST 7'h00
`define ADCC_FILT_RST 2'h0
`define ADCC_MODE_RST 2'h0

`define ADCC_CMD_SGL_GO 0
`define ADCC_CMD_SGL_HALT 1
`define ADCC_CMD_SEQ_GO 2
`define ADCC_CMD_SEQ_HALT 3

`define ADCC_OVS_EN_BIT 4
`define ADCC_OVS_CODE_MAX 4'hB
`define ADCC_BG_MULT 8'h05

`define ADCC_FILT_ONCHIP_DECOUPLING 2'h1
`define ADCC_FILT_RC 2'h2
`define ADCC_MODE_FASTREF 2'h1
`define ADCC_MODE_KEEPREF 2'h2
`define ADCC_MODE_KEEPALL 2'h3

`endif

// ### design/adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;

  typedef struct packed {
    logic [4:0] warmup_time_unit;
    logic [6:0] clock_divider_setting;
    logic [1:0] input_filter_select;
    logic single_after_scan;
    logic [1:0] warm_retention_select;
  } adcc_ctrl_t;

  typedef struct packed {
    logic power_en;
    logic ref_en;
    logic onchip_decoupling;
    logic resistor_capacitor_filter;
    logic sample_req;
    logic sample_scan;
    logic conv_clk;
  } adcc_core_t;

  typedef enum logic [3:0] {
    ADCC_S_IDLE = 4'b0001,
    ADCC_S_WARM = 4'b0010,
    ADCC_S_REFW = 4'b0100,
    ADCC_S_CONV = 4'b1000
  } adcc_state_t;

endpackage : adcc_pkg

// ### design/adcc_timer.sv
// cycle counter that flags every len-th cycle while run is held
`timescale 1ns/1ps
module adcc_timer #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [W-1:0] len,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] last;

  // a shortened len mid-count ends the period at once instead of wrapping
  assign last = len - {{(W-1){1'b0}}, 1'b1};
  assign done = run && (cnt_r >= last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!run || done) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule : adcc_timer

// ### sim/adcc_core_model.sv
// behavioural analog core: answers each sample request with one sample
`timescale 1ns/1ps
module adcc_core_model (
  input wire logic pclk,
  input adcc_pkg::adcc_core_t core,
  input wire logic [11:0] value,
  input wire logic [3:0] lat,
  output logic core_done,
  output logic [11:0] core_data
);
  import adcc_pkg::*;

  initial begin
    core_done = 1'b0;
    core_data = 12'h000;
  end

  // done is held three cycles because the design only sees it after two
  // flops; the data bus is scrambled once done falls so stale values show
  always begin
    @(posedge pclk);
    if (core.sample_req === 1'b1) begin
      repeat (lat) @(posedge pclk);
      core_data <= value;
      @(posedge pclk);
      core_done <= 1'b1;
      repeat (3) @(posedge pclk);
      core_done <= 1'b0;
      core_data <= ~value;
    end
  end
endmodule : adcc_core_model

// ### sim/adc_control_and_command_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adc_control_and_command_bench;
  import adcc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  adcc_core_t core;
  logic core_done;
  logic [11:0] core_data;
  logic [11:0] val = 12'h5A5;
  logic [3:0] lat = 4'h0;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int checks = 0;
  int n_req = 0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) if (core.sample_req === 1'b1) n_req <= n_req + 1;

  adcc_top i_adcc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core, .core_done, .core_data);
  adcc_core_model i_adcc_core_model (.pclk, .core, .value(val), .lat,
    .core_done, .core_data);

  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic hang(input string what);
    n_fail++;
    $display("wrong value %s expected done seen timeout", what);
    give_verdict();
  endtask : hang

  // one APB transfer; the idle cycle in front keeps psel single-driven
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_stat(input logic [31:0] m);
    int i;
    for (i = 0; i < 20000; i++) begin
      apb(1'b0, `ADCC_OFF_STATUS, 32'h0);
      if ((rd & m) === m) break;
    end
    if (i == 20000) hang("status");
  endtask : wait_stat

  function automatic logic [31:0] ctl(int t, int d, int f, int g, int m);
    return 32'((t << 16) | (d << 8) | (f << 4) | (g << 3) | m);
  endfunction : ctl

  initial begin
    int t;
    int c;
    int d;
    int e;
    logic p;
    void'($urandom(55));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    val = 12'($urandom);
    apb(1'b0, `ADCC_OFF_CTRL, 32'h0);
    // no time unit reaches 1 us at this clock, so warm-ups are short here
    chk("ctrl reset", 32'h001F0000, rd);
    apb(1'b1, `ADCC_OFF_CTRL, 32'h001F7F3B);
    apb(1'b0, `ADCC_OFF_CTRL, 32'h0);
    chk("ctrl fields", 32'h001F7F3B, rd);
    apb(1'b0, `ADCC_OFF_CMD, 32'h0);
    chk("cmd read", 32'h0, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");

    // scan jobs in every retention mode; mode 2 leaves the reference warm
    for (int m = 0; m < 4; m++) begin
      t = $urandom_range(0, 3);
      apb(1'b1, `ADCC_OFF_CTRL, ctl(t, 0, 0, 0, m));
      apb(1'b1, `ADCC_OFF_CMD, 32'h4);
      for (c = 0; c < 99 && core.power_en !== 1'b1; c++) @(posedge pclk);
      for (c = 0; c < 99 && core.sample_req !== 1'b1; c++) @(posedge pclk);
      e = (m == 1 || m == 3) ? t + 2 : 6 * (t + 1) + 1;
      chk("warm cycles", 32'(e), 32'(c));
      chk("scan flag", 32'h1, {31'h0, core.sample_scan});
      wait_stat(32'h200);
      apb(1'b0, `ADCC_OFF_QDATA, 32'h0);
      chk("scan result", {20'h0, val}, rd);
      repeat (3) @(posedge pclk);
      chk("power kept", 32'(m == 3), {31'h0, core.power_en});
      chk("ref kept", 32'(m >= 2), {31'h0, core.ref_en});
    end
    $display("test retention done");

    lat = 4'hF;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 0 : $urandom_range(1, 9);
      apb(1'b1, `ADCC_OFF_CTRL, ctl(0, d, i, 0, 3));
      // the filter pins are registered from the control register
      repeat (2) @(posedge pclk);
      chk("filter", 32'(i), {30'h0, core.resistor_capacitor_filter,
        core.onchip_decoupling});
      apb(1'b1, `ADCC_OFF_CMD, 32'h1);
      p = core.conv_clk;
      for (c = 0; c < 99 && core.conv_clk === p; c++) @(posedge pclk);
      p = core.conv_clk;
      for (c = 0; c < 99 && core.conv_clk === p; c++) @(posedge pclk);
      chk("divider", 32'(d + 1), 32'(c));
      wait_stat(32'h100);
      chk("single flag", 32'h0, {31'h0, core.sample_scan});
      apb(1'b0, `ADCC_OFF_SDATA, 32'h0);
    end
    $display("test divider done");

    apb(1'b1, `ADCC_OFF_CTRL, ctl(0, 0, 0, 1, 3));
    apb(1'b1, `ADCC_OFF_CMD, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, `ADCC_OFF_STATUS, 32'h0);
    chk("lone single", 32'h4, rd & 32'h7);
    apb(1'b1, `ADCC_OFF_CMD, 32'h4);
    wait_stat(32'h300);
    apb(1'b0, `ADCC_OFF_SDATA, 32'h0);
    apb(1'b0, `ADCC_OFF_QDATA, 32'h0);
    apb(1'b1, `ADCC_OFF_CTRL, ctl(0, 0, 0, 0, 3));
    apb(1'b1, `ADCC_OFF_CMD, 32'h1);
    apb(1'b1, `ADCC_OFF_CMD, 32'h4);
    apb(1'b0, `ADCC_OFF_STATUS, 32'h0);
    chk("scan waits", 32'h9, rd & 32'hB);
    wait_stat(32'h300);
    apb(1'b0, `ADCC_OFF_SDATA, 32'h0);
    apb(1'b0, `ADCC_OFF_QDATA, 32'h0);
    $display("test priority done");

    // stop while the core still owes a sample: no result may appear
    for (int k = 0; k < 2; k++) begin
      c = n_req;
      apb(1'b1, `ADCC_OFF_CMD, 32'(1 << (2 * k)));
      for (e = 0; e < 200 && n_req == c; e++) @(posedge pclk);
      apb(1'b1, `ADCC_OFF_CMD, 32'(2 << (2 * k)));
      apb(1'b1, `ADCC_OFF_CMD, 32'h0);
      apb(1'b0, `ADCC_OFF_STATUS, 32'h0);
      chk("stopped", 32'h0, rd & 32'h303);
      // the core still answers the abandoned sample; let that done pass
      // so it cannot be counted as a sample of the next job
      repeat (30) @(posedge pclk);
    end
    $display("test stop done");

    lat = 4'h0;
    repeat (30) @(posedge pclk);
    for (int code = 9; code < 12; code++) begin
      apb(1'b1, `ADCC_OFF_OVS, 32'(32'h10 | code));
      n_req = 0;
      apb(1'b1, `ADCC_OFF_CMD, 32'h1);
      wait_stat(32'h100);
      chk("samples", 32'(1 << (code + 1)), 32'(n_req));
      apb(1'b0, `ADCC_OFF_SDATA, 32'h0);
      chk("average", {20'h0, val}, rd);
    end
    $display("test oversampling done");
    give_verdict();
  end
endmodule : adc_control_and_command_bench
